// ---- inc/tws_pkg.sv ----
// Constants and types for the two-wire slave transmitter status block.
// Assumes a single system clock; the bus pins are sampled, not clocked on.
package tws_pkg;

   // Register byte offsets
   localparam logic [7:0] TWS_OFS_CTRL = 8'h00;
   localparam logic [7:0] TWS_OFS_STAT = 8'h04;
   localparam logic [7:0] TWS_OFS_DATA = 8'h08;
   localparam logic [7:0] TWS_OFS_OWN = 8'h0C;

   // Control register bit positions
   localparam int TWS_CTRL_FLAG = 7;
   localparam int TWS_CTRL_ACKEN = 6;
   localparam int TWS_CTRL_START = 5;
   localparam int TWS_CTRL_STOP = 4;
   localparam int TWS_CTRL_EN = 2;

   // Values after reset
   localparam logic [7:0] TWS_DATA_RST = 8'hFF;
   localparam logic [7:0] TWS_OWN_RST = 8'h00;

   // Status codes, prescaler bits taken as zero
   localparam logic [7:0] TWS_ST_SLA_R = 8'hA8;
   localparam logic [7:0] TWS_ST_ARB_R = 8'hB0;
   localparam logic [7:0] TWS_ST_DATA_ACK = 8'hB8;
   localparam logic [7:0] TWS_ST_DATA_NACK = 8'hC0;
   localparam logic [7:0] TWS_ST_LAST_ACK = 8'hC8;
   localparam logic [7:0] TWS_ST_NONE = 8'hF8;
   localparam logic [7:0] TWS_ST_BUSERR = 8'h00;
   localparam logic [7:0] TWS_CODE_MASK = 8'hF8;

   // Bits in a byte, counted without the acknowledge
   localparam logic [3:0] TWS_BYTE_BITS = 4'h8;

   typedef enum logic [2:0] {
      TWS_IDLE,
      TWS_ADDR,
      TWS_ADDR_ACK,
      TWS_HOLD,
      TWS_TX,
      TWS_TX_ACK,
      TWS_IGNORE,
      TWS_BERR
   } tws_phase_t;

   // Open-drain line drive; enable high pulls the line low
   typedef struct packed {
      logic scl_o;
      logic scl_oe;
      logic sda_o;
      logic sda_oe;
   } tws_lines_t;

   typedef struct packed {
      // Software-visible control and data
      logic flag;
      logic ack_en;
      logic start_req;
      logic stop_req;
      logic enable;
      logic [7:0] code;
      logic [7:0] data;
      logic [7:0] own;
      // Pin samplers and filtered levels
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic scl_f;
      logic sda_f;
      // Serial engine
      tws_phase_t phase;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic arb;
      logic last;
      logic ack_seen;
      logic busy;
      logic start_pend;
      logic start_issue;
      logic sda_oe;
      logic scl_hold;
      // Bus slave data phase
      logic ph_valid;
      logic ph_write;
      logic [7:0] ph_addr;
      logic rd_done;
      logic [31:0] hrdata;
   } tws_state_t;

endpackage : tws_pkg

// ---- src/tws_slave_tx.sv ----
// Two-wire slave transmitter with status sequencing and an AHB-Lite register slave.
// Assumes SCL and SDA arrive asynchronously and are wired open-drain outside.
//
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module tws_slave_tx
   import tws_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic scl_i,
   input wire logic sda_i,
   output var tws_lines_t lines,
   input wire logic arb_lost,
   output logic start_issue
);

   tws_state_t q;
   tws_state_t d;
   logic scl_n;
   logic sda_n;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic in_frame;
   logic wr_ctrl;
   logic flag_clr;
   logic [7:0] stat_w;

   // Status byte as software sees it
   function automatic logic [7:0] status_byte(input logic flag, input logic [7:0] code);
      status_byte = flag ? (code & TWS_CODE_MASK) : TWS_ST_NONE;
   endfunction : status_byte

   // Own address or general call, gated by acknowledge-enable
   function automatic logic addr_hit(input logic [7:0] own, input logic [7:0] rx,
                                     input logic ack_en, input logic en);
      addr_hit = en && ack_en && ((rx[7:1] == own[7:1])
         || (rx[7:1] == 7'h00 && own[0]));
   endfunction : addr_hit

   // Filtered levels and bus conditions
   always_comb
   begin
      scl_n = (q.scl_s[1] == q.scl_s[2]) ? q.scl_s[2] : q.scl_f;
      sda_n = (q.sda_s[1] == q.sda_s[2]) ? q.sda_s[2] : q.sda_f;
      scl_rise = scl_n && !q.scl_f;
      scl_fall = !scl_n && q.scl_f;
      start_det = scl_n && q.scl_f && q.sda_f && !sda_n;
      stop_det = scl_n && q.scl_f && !q.sda_f && sda_n;
      in_frame = (q.phase == TWS_ADDR && q.bit_cnt != 4'h0) || q.phase == TWS_ADDR_ACK
         || q.phase == TWS_TX || q.phase == TWS_TX_ACK;
      wr_ctrl = q.ph_valid && q.ph_write && q.ph_addr == TWS_OFS_CTRL;
      flag_clr = wr_ctrl && hwdata[TWS_CTRL_FLAG] && q.flag;
      stat_w = status_byte(q.flag, q.code);
   end

   // Next-state logic
   always_comb
   begin
      d = q;
      d.scl_s = {q.scl_s[1:0], scl_i};
      d.sda_s = {q.sda_s[1:0], sda_i};
      d.scl_f = scl_n;
      d.sda_f = sda_n;
      d.start_issue = 1'b0;

      // Bus slave: reads take one wait cycle so earlier writes have landed
      if (q.ph_valid && !q.ph_write && !q.rd_done)
      begin
         d.rd_done = 1'b1;
         case (q.ph_addr)
            TWS_OFS_CTRL: d.hrdata = {24'h0, q.flag, q.ack_en, q.start_req, q.stop_req,
                                      1'b0, q.enable, 2'b00};
            TWS_OFS_STAT: d.hrdata = {24'h0, stat_w};
            TWS_OFS_DATA: d.hrdata = {24'h0, q.data};
            TWS_OFS_OWN: d.hrdata = {24'h0, q.own};
            default: d.hrdata = 32'h0;
         endcase
      end
      else
      begin
         d.ph_valid = hsel && htrans[1] && hready;
         d.ph_write = hwrite;
         d.ph_addr = {haddr[7:2], 2'b00};
         d.rd_done = 1'b0;
      end

      // Register writes; the flag clears only on a written one
      if (q.ph_valid && q.ph_write)
      begin
         case (q.ph_addr)
            TWS_OFS_CTRL:
            begin
               d.ack_en = hwdata[TWS_CTRL_ACKEN];
               d.start_req = hwdata[TWS_CTRL_START];
               d.stop_req = hwdata[TWS_CTRL_STOP];
               d.enable = hwdata[TWS_CTRL_EN];
               if (flag_clr)
               begin
                  d.flag = 1'b0;
               end
            end
            TWS_OFS_DATA: d.data = hwdata[7:0];
            TWS_OFS_OWN: d.own = hwdata[7:0];
            default: d.data = q.data;
         endcase
      end

      // Software answers to the current status
      if (flag_clr)
      begin
         if (q.phase == TWS_HOLD)
         begin
            d.shift = q.data;
            d.last = !hwdata[TWS_CTRL_ACKEN];
            d.sda_oe = !q.data[7];
            d.bit_cnt = 4'h1;
            d.scl_hold = 1'b0;
            d.phase = TWS_TX;
         end
         else if (q.phase == TWS_BERR && hwdata[TWS_CTRL_STOP])
         begin
            d.phase = TWS_IDLE;
            d.stop_req = 1'b0;
         end
         else if ((q.code == TWS_ST_DATA_NACK || q.code == TWS_ST_LAST_ACK)
                  && hwdata[TWS_CTRL_START])
         begin
            d.start_pend = 1'b1;
         end
      end

      // Pending START goes out once the bus is free
      if (q.start_pend && !q.busy && !start_det)
      begin
         d.start_issue = 1'b1;
         d.start_pend = 1'b0;
      end

      // Serial engine; the flag is set after any clear so a set wins
      case (q.phase)
         TWS_ADDR:
         begin
            if (scl_rise)
            begin
               d.shift = {q.shift[6:0], sda_n};
               d.bit_cnt = q.bit_cnt + 4'h1;
            end
            else if (scl_fall && q.bit_cnt == TWS_BYTE_BITS)
            begin
               d.bit_cnt = 4'h0;
               if (q.shift[0] && addr_hit(q.own, q.shift, q.ack_en, q.enable))
               begin
                  d.sda_oe = 1'b1;
                  d.phase = TWS_ADDR_ACK;
               end
               else
               begin
                  d.phase = TWS_IDLE;
               end
            end
         end
         TWS_ADDR_ACK:
         begin
            if (scl_fall)
            begin
               d.sda_oe = 1'b0;
               d.flag = 1'b1;
               d.code = q.arb ? TWS_ST_ARB_R : TWS_ST_SLA_R;
               d.scl_hold = 1'b1;
               d.phase = TWS_HOLD;
            end
         end
         TWS_TX:
         begin
            if (scl_fall)
            begin
               if (q.bit_cnt == TWS_BYTE_BITS)
               begin
                  d.sda_oe = 1'b0;
                  d.phase = TWS_TX_ACK;
               end
               else
               begin
                  d.shift = {q.shift[6:0], 1'b1};
                  d.sda_oe = !q.shift[6];
                  d.bit_cnt = q.bit_cnt + 4'h1;
               end
            end
         end
         TWS_TX_ACK:
         begin
            if (scl_rise)
            begin
               d.ack_seen = !sda_n;
            end
            else if (scl_fall)
            begin
               d.flag = 1'b1;
               d.bit_cnt = 4'h0;
               if (!q.ack_seen)
               begin
                  d.code = TWS_ST_DATA_NACK;
                  d.phase = TWS_IDLE;
               end
               else if (q.last)
               begin
                  d.code = TWS_ST_LAST_ACK;
                  d.phase = TWS_IGNORE;
               end
               else
               begin
                  d.code = TWS_ST_DATA_ACK;
                  d.scl_hold = 1'b1;
                  d.phase = TWS_HOLD;
               end
            end
         end
         default: d.phase = d.phase;
      endcase

      // Bus conditions override the engine
      if (start_det || stop_det)
      begin
         d.busy = start_det;
         if (in_frame)
         begin
            d.phase = TWS_BERR;
            d.code = TWS_ST_BUSERR;
            d.flag = 1'b1;
            d.sda_oe = 1'b0;
            d.scl_hold = 1'b0;
         end
         else if (q.phase != TWS_BERR && q.phase != TWS_HOLD)
         begin
            d.phase = start_det ? TWS_ADDR : TWS_IDLE;
            d.bit_cnt = 4'h0;
            d.arb = arb_lost;
         end
      end
   end

   // State register, frozen while the clock enable is low
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         q <= '{phase: TWS_IDLE, data: TWS_DATA_RST, own: TWS_OWN_RST,
                scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1, default: '0};
      end
      else if (ce)
      begin
         q <= d;
      end
   end

   // Outputs
   assign hreadyout = ce && !(q.ph_valid && !q.ph_write && !q.rd_done);
   assign hresp = 1'b0;
   assign hrdata = q.hrdata;
   assign lines = '{scl_o: 1'b0, scl_oe: q.scl_hold && q.flag, sda_o: 1'b0, sda_oe: q.sda_oe};
   assign start_issue = q.start_issue;

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   property p_sla_r;
      (ce && q.phase == TWS_ADDR_ACK && scl_fall && !q.arb && !start_det && !stop_det)
         |=> (q.flag && q.code == TWS_ST_SLA_R && lines.scl_oe);
   endproperty
   a_sla_r: assert property (p_sla_r) else $error("no A8 after address ack");

   property p_arb_r;
      (ce && q.phase == TWS_ADDR_ACK && scl_fall && q.arb && !start_det && !stop_det)
         |=> (q.flag && q.code == TWS_ST_ARB_R);
   endproperty
   a_arb_r: assert property (p_arb_r) else $error("no B0 after lost arbitration");

   property p_tx_ack;
      (ce && q.phase == TWS_TX_ACK && scl_fall && q.ack_seen && !q.last && !start_det
         && !stop_det) |=> (q.code == TWS_ST_DATA_ACK && q.phase == TWS_HOLD);
   endproperty
   a_tx_ack: assert property (p_tx_ack) else $error("no B8 after acked byte");

   property p_tx_nack;
      (ce && q.phase == TWS_TX_ACK && scl_fall && !q.ack_seen && !start_det && !stop_det)
         |=> (q.code == TWS_ST_DATA_NACK && q.phase == TWS_IDLE && q.flag);
   endproperty
   a_tx_nack: assert property (p_tx_nack) else $error("no C0 after nack");

   property p_last_ack;
      (ce && q.phase == TWS_TX_ACK && scl_fall && q.ack_seen && q.last && !start_det
         && !stop_det) |=> (q.code == TWS_ST_LAST_ACK && q.phase == TWS_IGNORE);
   endproperty
   a_last_ack: assert property (p_last_ack) else $error("no C8 after final byte");

   property p_load;
      (ce && flag_clr && q.phase == TWS_HOLD)
         |=> (q.phase == TWS_TX && q.last == !$past(hwdata[TWS_CTRL_ACKEN]) && !lines.scl_oe);
   endproperty
   a_load: assert property (p_load) else $error("byte not started on flag clear");

   property p_none;
      (ce && q.ph_valid && !q.ph_write && !q.rd_done && q.ph_addr == TWS_OFS_STAT)
         |=> (hrdata[2:0] == 3'h0 && ($past(q.flag) || hrdata[7:0] == TWS_ST_NONE));
   endproperty
   a_none: assert property (p_none) else $error("status not F8 with flag clear");

   property p_berr;
      (ce && in_frame && (start_det || stop_det))
         |=> (q.phase == TWS_BERR && q.flag && q.code == TWS_ST_BUSERR);
   endproperty
   a_berr: assert property (p_berr) else $error("bus error not flagged");

   property p_recover;
      (ce && flag_clr && q.phase == TWS_BERR && hwdata[TWS_CTRL_STOP] && !start_det && !stop_det)
         |=> (q.phase == TWS_IDLE && !q.stop_req && !lines.sda_oe && !lines.scl_oe);
   endproperty
   a_recover: assert property (p_recover) else $error("bus error recovery wrong");

   property p_ignore;
      q.phase == TWS_IGNORE || q.phase == TWS_BERR |-> !lines.sda_oe && !lines.scl_oe;
   endproperty
   a_ignore: assert property (p_ignore) else $error("line driven while ignoring");

endmodule : tws_slave_tx
`default_nettype wire

// ---- verification/tws_master_model.sv ----
// Behavioural two-wire bus master acting as receiver, driven by bench tasks.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/10ps
`default_nettype none
module tws_master_model (
   input wire logic scl_line,
   input wire logic sda_line,
   output logic scl_pull,
   output logic sda_pull,
   output logic [7:0] rx_byte,
   output logic rx_stb
);
   localparam int Q = 50; // Quarter of the 200 ns bus period

   // Lines released at time zero
   initial
   begin
      scl_pull = 1'h0;
      sda_pull = 1'h0;
      rx_byte = 8'h00;
      rx_stb = 1'h0;
   end

   // SDA falls while SCL is high
   task automatic start();
      #(2*Q) sda_pull = 1'h1;
      #(2*Q) scl_pull = 1'h1;
   endtask : start

   // One bit; data set while SCL low, sampled once SCL really rises
   task automatic bit_io(input logic b, output logic r);
      #Q sda_pull = !b;
      #Q scl_pull = 1'h0;
      #1 wait (scl_line === 1'h1); // Clock stretching honoured, after the slave's hold settles
      #Q r = sda_line;
      #Q scl_pull = 1'h1;
   endtask : bit_io

   // SDA rises while SCL is high
   task automatic stop();
      #Q sda_pull = 1'h1;
      #Q scl_pull = 1'h0;
      wait (scl_line === 1'h1);
      #(2*Q) sda_pull = 1'h0;
      #(2*Q);
   endtask : stop

   // First n bits of a byte, MSB first, then the answer bit when whole
   task automatic wr_byte(input logic [7:0] v, input int n, output logic ack);
      for (int i = 7; i > 7 - n; i--)
         bit_io(v[i], ack);
      if (n == 8)
         bit_io(1'h1, ack);
   endtask : wr_byte

   // Eight bits read, then ACK (nack low) or NOT ACK
   task automatic rd_byte(input logic nack);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'h1, r);
         rx_byte[i] = r;
      end
      rx_stb = 1'h1;
      #1 rx_stb = 1'h0;
      bit_io(nack, r);
   endtask : rd_byte
endmodule : tws_master_model
`default_nettype wire

// ---- verification/test_tws_slave_tx.sv ----
// Self-checking bench for the two-wire slave transmitter status block.
// Assumes the master model file and a single AHB-Lite master on one slave.
`timescale 1ns/10ps
`default_nettype none
module test_tws_slave_tx
   import tws_pkg::*;
;
   localparam logic [6:0] ADR = 7'h35;
   logic clock, srst, ce, hsel, hwrite, arb_lost, ack, hreadyout, hresp, start_issue;
   logic rd_ph = 1'h0;
   logic [2:0] hsize;
   logic m_scl, m_sda, m_stb, scl_w, sda_w;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, seed;
   logic [7:0] m_byte, d;
   tws_lines_t lines;
   int num_errors, num_checks, cyc, n_st;
   logic [31:0] exp_rd[$];
   logic [7:0] exp_by[$];

   // Wired-AND bus lines with pull-ups
   assign scl_w = !(m_scl | lines.scl_oe);
   assign sda_w = !(m_sda | lines.sda_oe);

   tws_slave_tx tws_slave_tx_i (.clock(clock), .srst(srst), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .scl_i(scl_w), .sda_i(sda_w), .lines(lines), .arb_lost(arb_lost),
      .start_issue(start_issue));

   tws_master_model tws_master_model_i (.scl_line(scl_w), .sda_line(sda_w),
      .scl_pull(m_scl), .sda_pull(m_sda), .rx_byte(m_byte), .rx_stb(m_stb));

   // 40 MHz clock
   initial
   begin
      clock = 1'h0;
      forever #12.5 clock = !clock;
   end

   task automatic give_verdict();
      if (num_errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Read data phases, start pulses and the hang limit
   always @(posedge clock)
   begin
      if (rd_ph && hreadyout === 1'h1)
      begin
         chk(hrdata, exp_rd.pop_front());
         chk({31'h0, hresp}, 32'h0);
      end
      if (hsel && htrans[1] && hreadyout)
         rd_ph <= !hwrite;
      else if (hreadyout)
         rd_ph <= 1'h0;
      if (start_issue === 1'h1)
         n_st <= n_st + 1;
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         num_errors++;
         give_verdict();
      end
   end

   // Bytes seen by the master against the oldest note
   always @(posedge m_stb)
      chk({24'h0, m_byte}, {24'h0, exp_by.pop_front()});

   function automatic logic [7:0] nxt();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : nxt

   task automatic w(input int n);
      repeat (n) @(posedge clock);
   endtask : w

   // Single word transfer: address phase, then data phase until ready
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clock);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge clock); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clock); while (hreadyout !== 1'h1);
   endtask : ahb

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      exp_rd.push_back(exp);
      ahb(1'h0, a, 32'h0);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      ahb(1'h1, a, v);
   endtask : wr

   // Software answer to an addressed state while SCL is stretched
   task automatic serve(input logic [7:0] code, input logic [31:0] ctl);
      w(20);
      chk({31'h0, lines.scl_oe}, 32'h1);
      rd(TWS_OFS_STAT, {24'h0, code});
      d = nxt();
      exp_by.push_back(d);
      wr(TWS_OFS_DATA, {24'h0, d});
      wr(TWS_OFS_CTRL, ctl);
   endtask : serve

   task automatic address(input logic nack_exp);
      tws_master_model_i.start();
      tws_master_model_i.wr_byte({ADR, 1'h1}, 8, ack);
      chk({31'h0, ack}, {31'h0, nack_exp});
   endtask : address

   // Main sequence
   initial
   begin
      srst = 1'h1;
      hsel = 1'h0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'h0;
      hwdata = 32'h0;
      arb_lost = 1'h0;
      ce = 1'h1;
      hsize = 3'h2;
      seed = 32'h00000048; // Seed 72
      num_errors = 0;
      num_checks = 0;
      w(16);
      srst <= 1'h0;
      rd(TWS_OFS_CTRL, 32'h0);
      rd(TWS_OFS_DATA, {24'h0, TWS_DATA_RST});
      rd(TWS_OFS_OWN, {24'h0, TWS_OWN_RST});
      rd(TWS_OFS_STAT, {24'h0, TWS_ST_NONE});
      rd(8'h10, 32'h0);
      // Clock enable low stalls the bus and freezes the registers
      ce <= 1'h0;
      w(3);
      chk({31'h0, hreadyout}, 32'h0);
      ce <= 1'h1;
      wr(TWS_OFS_OWN, {24'h0, ADR, 1'h1});
      rd(TWS_OFS_OWN, {24'h0, ADR, 1'h1});
      wr(TWS_OFS_CTRL, 32'h44);
      // Two bytes, the final one refused by the master
      address(1'h0);
      fork
         tws_master_model_i.rd_byte(1'h0);
         serve(TWS_ST_SLA_R, 32'hC4);
      join
      fork
         tws_master_model_i.rd_byte(1'h1);
         serve(TWS_ST_DATA_ACK, 32'h84);
      join
      w(10);
      rd(TWS_OFS_STAT, {24'h0, TWS_ST_DATA_NACK});
      rd(TWS_OFS_CTRL, 32'h84);
      wr(TWS_OFS_CTRL, 32'hC4);
      rd(TWS_OFS_STAT, {24'h0, TWS_ST_NONE});
      tws_master_model_i.stop();
      // Final byte acknowledged, then the master reads on unanswered
      address(1'h0);
      fork
         tws_master_model_i.rd_byte(1'h0);
         serve(TWS_ST_SLA_R, 32'h84);
      join
      w(10);
      rd(TWS_OFS_STAT, {24'h0, TWS_ST_LAST_ACK});
      exp_by.push_back(8'hFF);
      tws_master_model_i.rd_byte(1'h1);
      wr(TWS_OFS_CTRL, 32'h84);
      tws_master_model_i.stop();
      address(1'h1);
      tws_master_model_i.stop();
      wr(TWS_OFS_CTRL, 32'h44);
      // Addressed after lost arbitration, START requested on leaving
      arb_lost <= 1'h1;
      address(1'h0);
      @(posedge clock);
      arb_lost <= 1'h0;
      fork
         tws_master_model_i.rd_byte(1'h1);
         serve(TWS_ST_ARB_R, 32'h84);
      join
      w(10);
      rd(TWS_OFS_STAT, {24'h0, TWS_ST_DATA_NACK});
      wr(TWS_OFS_CTRL, 32'hA4);
      w(40);
      chk(n_st, 32'h0);
      tws_master_model_i.stop();
      w(40);
      chk(n_st, 32'h1);
      wr(TWS_OFS_CTRL, 32'h44);
      // STOP in the middle of an address byte
      tws_master_model_i.start();
      tws_master_model_i.wr_byte({ADR, 1'h1}, 3, ack);
      tws_master_model_i.stop();
      w(10);
      rd(TWS_OFS_STAT, {24'h0, TWS_ST_BUSERR});
      rd(TWS_OFS_CTRL, 32'hC4);
      chk({28'h0, lines}, 32'h0);
      wr(TWS_OFS_CTRL, 32'hD4);
      rd(TWS_OFS_CTRL, 32'h44);
      rd(TWS_OFS_STAT, {24'h0, TWS_ST_NONE});
      chk({28'h0, lines}, 32'h0);
      give_verdict();
   end
endmodule : test_tws_slave_tx
`default_nettype wire
